// File: inc/fls_defs.svh
/*
 * Register offsets, field positions, command bytes and timing counts
 * for the lock-bit host controller. Definitions only.
 * Assumes: included by bare name from the rtl files.
 */
`ifndef FLS_DEFS_SVH
`define FLS_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define FLS_OFS_CTRL 12'h000
`define FLS_OFS_ADDR 12'h004
`define FLS_OFS_STAT 12'h008

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define FLS_CTRL_OP_LSB 0
`define FLS_CTRL_OP_MSB 2
`define FLS_CTRL_GO 8
`define FLS_CTRL_HV 9
`define FLS_CTRL_PD 10
`define FLS_CTRL_CLR 11

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define FLS_STAT_SR_MSB 7
`define FLS_STAT_BUSY 8
`define FLS_STAT_RYBY 9
`define FLS_STAT_ERR 10
`define FLS_STAT_ABORT 11
`define FLS_STAT_DONE 12

// ----------------------------------------------------------------
// device status byte bits
// ----------------------------------------------------------------
`define FLS_SR_READY 7
`define FLS_SR_ERASE_ERR 5
`define FLS_SR_PROG_ERR 4
`define FLS_SR_VPP_ERR 3
`define FLS_SR_PROTECT 1

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define FLS_CMD_LOCK_SETUP 8'h60
`define FLS_CMD_CLR_CONFIRM 8'hD0
`define FLS_CMD_SET_BLOCK 8'h01
`define FLS_CMD_SET_MASTER 8'hF1
`define FLS_CMD_CLR_STATUS 8'h50
`define FLS_CMD_READ_ARRAY 8'hFF

// ----------------------------------------------------------------
// timing: pclk cycles per bus phase, address width, reset values
// ----------------------------------------------------------------
`define FLS_TICK_DIV 4
`define FLS_ADDR_W 20
`define FLS_RST_CTRL 32'h0000_0000

`endif

// File: inc/fls_pkg.sv
/*
 * Types shared by the lock-bit host controller files.
 * Assumes: constants come from fls_defs.svh.
 */
package fls_pkg;

    typedef enum logic [2:0] {
        FLS_OP_NONE,
        FLS_OP_CLR_LOCK,
        FLS_OP_SET_BLOCK,
        FLS_OP_SET_MASTER,
        FLS_OP_CLR_STAT,
        FLS_OP_RD_ARRAY
    } fls_op_e;

    typedef enum logic [2:0] {
        FLS_ST_IDLE,
        FLS_ST_WR,
        FLS_ST_RDS,
        FLS_ST_CLS,
        FLS_ST_FFW
    } fls_state_e;

endpackage : fls_pkg

// File: rtl/fls_tick.sv
/*
 * Enable divider: one-cycle pulse every DIV pclk cycles.
 * Assumes: single pclk domain, asynchronous active-low reset.
 */
`timescale 1ns/1ps
`include "fls_defs.svh"

module fls_tick #(
    parameter int DIV = `FLS_TICK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;

    always_comb begin
        if (cnt == 8'(DIV - 1)) begin
            next_cnt = 8'h00;
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick = (cnt == 8'(DIV - 1));

endmodule : fls_tick

// File: rtl/fls_host.sv
/*
 * Host-side controller for a byte-wide flash lock-bit interface:
 * APB register slave, command-sequence engine and flash pin driver.
 * Assumes: flash pins are synchronous to pclk; the device answers
 * status reads within one bus phase; zero-wait APB master.
 */
// Functional notes
// - clear lock bits is write 60h then D0h, any address, in order.
// - after clear lock bits finishes, write FFh to return to array reads.
// - on any error host issues clear-status before retry or recovery.
// - after a reset abort, host repeats the whole command sequence; the engine only goes idle and sets abort.
`timescale 1ns/1ps
`include "fls_defs.svh"

module fls_host #(
    parameter int AW = `FLS_ADDR_W,
    parameter int DIV = `FLS_TICK_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [AW-1:0] flash_addr,
    output logic [7:0] dq_out,
    input wire logic [7:0] dq_in,
    output logic dq_oe_n,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic reset_powerdown_n,
    output logic high_voltage_override_level,
    input wire logic ready_busy_n
);
    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    logic tick;
    logic acc;
    logic wr_ctrl, wr_addr, hit;
    fls_pkg::fls_op_e op, next_op;
    logic hv, next_hv, pd, next_pd;
    logic [AW-1:0] addr_reg, next_addr_reg;
    logic err, next_err, abort, next_abort, done, next_done;
    logic go;
    logic [7:0] sr, next_sr;
    fls_pkg::fls_state_e st, next_st;
    logic [1:0] phase, next_phase;
    logic step, next_step;
    logic busy;
    logic fin, sr_bad;

    fls_tick #(.DIV(DIV)) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign acc = psel && penable;
    assign hit = (paddr == `FLS_OFS_CTRL) || (paddr == `FLS_OFS_ADDR)
        || (paddr == `FLS_OFS_STAT);
    assign wr_ctrl = acc && pwrite && (paddr == `FLS_OFS_CTRL);
    assign wr_addr = acc && pwrite && (paddr == `FLS_OFS_ADDR);
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign busy = (st != fls_pkg::FLS_ST_IDLE);
    // start refused while busy or while the device is held powered down
    assign go = wr_ctrl && pwdata[`FLS_CTRL_GO] && !busy
        && !pwdata[`FLS_CTRL_PD] && !pd;

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == `FLS_OFS_CTRL) begin
            prdata[`FLS_CTRL_OP_MSB:`FLS_CTRL_OP_LSB] = op;
            prdata[`FLS_CTRL_HV] = hv;
            prdata[`FLS_CTRL_PD] = pd;
        end else if (paddr == `FLS_OFS_ADDR) begin
            prdata[AW-1:0] = addr_reg;
        end else if (paddr == `FLS_OFS_STAT) begin
            prdata[`FLS_STAT_SR_MSB:0] = sr;
            prdata[`FLS_STAT_BUSY] = busy;
            prdata[`FLS_STAT_RYBY] = ready_busy_n;
            prdata[`FLS_STAT_ERR] = err;
            prdata[`FLS_STAT_ABORT] = abort;
            prdata[`FLS_STAT_DONE] = done;
        end
    end

    always_comb begin
        next_op = op;
        next_hv = hv;
        next_pd = pd;
        next_addr_reg = addr_reg;
        next_err = err;
        next_abort = abort;
        next_done = done;
        if (wr_ctrl) begin
            next_hv = pwdata[`FLS_CTRL_HV];
            next_pd = pwdata[`FLS_CTRL_PD];
            if (pwdata[`FLS_CTRL_CLR]) begin
                next_err = 1'b0;
                next_abort = 1'b0;
                next_done = 1'b0;
            end
            if (go) begin
                next_op = fls_pkg::fls_op_e'(
                    pwdata[`FLS_CTRL_OP_MSB:`FLS_CTRL_OP_LSB]);
                next_done = 1'b0;
            end
        end
        if (wr_addr) begin
            next_addr_reg = pwdata[AW-1:0];
        end
        // hardware set wins over a clear in the same cycle
        if (fin) begin
            next_done = 1'b1;
        end
        // stale status byte must not flag a plain clear-status or read-array
        if (fin && sr_bad && lock_op) begin
            next_err = 1'b1;
        end
        if (pd && busy) begin
            next_abort = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= fls_pkg::FLS_OP_NONE;
            hv <= 1'b0;
            pd <= 1'b0;
            addr_reg <= '0;
            err <= 1'b0;
            abort <= 1'b0;
            done <= 1'b0;
        end else begin
            op <= next_op;
            hv <= next_hv;
            pd <= next_pd;
            addr_reg <= next_addr_reg;
            err <= next_err;
            abort <= next_abort;
            done <= next_done;
        end
    end

    // ----------------------------------------------------------------
    // command sequence engine
    // ----------------------------------------------------------------
    logic two_byte, lock_op;
    logic [7:0] wbyte;
    logic [7:0] next_dq_out;
    logic [AW-1:0] next_flash_addr;
    logic next_ce_n, next_we_n, next_oe_n, next_dq_oe_n;
    logic [7:0] last_byte, next_last_byte;

    assign lock_op = (op == fls_pkg::FLS_OP_CLR_LOCK)
        || (op == fls_pkg::FLS_OP_SET_BLOCK)
        || (op == fls_pkg::FLS_OP_SET_MASTER);
    assign two_byte = lock_op;
    // any of the sticky failure bits, incl. the 4+5 sequence error
    assign sr_bad = sr[`FLS_SR_ERASE_ERR] || sr[`FLS_SR_PROG_ERR]
        || sr[`FLS_SR_VPP_ERR] || sr[`FLS_SR_PROTECT];
    assign fin = busy && !pd && tick && (phase == 2'd3) && (
        st == fls_pkg::FLS_ST_FFW
        || (st == fls_pkg::FLS_ST_WR && !lock_op && (step || !two_byte)));

    always_comb begin
        wbyte = `FLS_CMD_READ_ARRAY;
        case (st)
            fls_pkg::FLS_ST_WR: begin
                if (!step) begin
                    case (op)
                        fls_pkg::FLS_OP_CLR_STAT:
                            wbyte = `FLS_CMD_CLR_STATUS;
                        fls_pkg::FLS_OP_RD_ARRAY:
                            wbyte = `FLS_CMD_READ_ARRAY;
                        // no lone setup byte for an undefined op code
                        default: wbyte = lock_op ? `FLS_CMD_LOCK_SETUP
                            : `FLS_CMD_READ_ARRAY;
                    endcase
                end else begin
                    case (op)
                        fls_pkg::FLS_OP_SET_BLOCK:
                            wbyte = `FLS_CMD_SET_BLOCK;
                        fls_pkg::FLS_OP_SET_MASTER:
                            wbyte = `FLS_CMD_SET_MASTER;
                        default: wbyte = `FLS_CMD_CLR_CONFIRM;
                    endcase
                end
            end
            fls_pkg::FLS_ST_CLS: wbyte = `FLS_CMD_CLR_STATUS;
            default: wbyte = `FLS_CMD_READ_ARRAY;
        endcase
    end

    // each bus cycle is four tick phases: set up, strobe, release, idle
    always_comb begin
        next_st = st;
        next_phase = phase;
        next_step = step;
        next_sr = sr;
        next_ce_n = ce_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        next_dq_oe_n = dq_oe_n;
        next_dq_out = dq_out;
        next_flash_addr = flash_addr;
        next_last_byte = last_byte;
        if (pd) begin
            // abort: release every control, device power-down
            next_st = fls_pkg::FLS_ST_IDLE;
            next_phase = 2'd0;
            next_step = 1'b0;
            next_ce_n = 1'b1;
            next_we_n = 1'b1;
            next_oe_n = 1'b1;
            next_dq_oe_n = 1'b1;
        end else if (st == fls_pkg::FLS_ST_IDLE) begin
            if (go) begin
                next_st = fls_pkg::FLS_ST_WR;
                next_phase = 2'd0;
                next_step = 1'b0;
            end
        end else if (tick) begin
            next_phase = phase + 2'd1;
            if (st == fls_pkg::FLS_ST_RDS) begin
                case (phase)
                    2'd0: begin
                        next_ce_n = 1'b0;
                        next_oe_n = 1'b0;
                    end
                    2'd1: next_sr = dq_in;
                    2'd2: begin
                        next_ce_n = 1'b1;
                        next_oe_n = 1'b1;
                    end
                    default: begin
                        if (sr[`FLS_SR_READY]) begin
                            next_st = sr_bad ? fls_pkg::FLS_ST_CLS
                                : fls_pkg::FLS_ST_FFW;
                        end
                    end
                endcase
            end else begin
                case (phase)
                    2'd0: begin
                        next_flash_addr = addr_reg;
                        next_dq_out = wbyte;
                        next_dq_oe_n = 1'b0;
                        next_ce_n = 1'b0;
                    end
                    2'd1: next_we_n = 1'b0;
                    2'd2: begin
                        next_we_n = 1'b1;
                        next_last_byte = dq_out;
                    end
                    default: begin
                        next_ce_n = 1'b1;
                        next_dq_oe_n = 1'b1;
                        if (st == fls_pkg::FLS_ST_CLS) begin
                            next_st = fls_pkg::FLS_ST_FFW;
                        end else if (st == fls_pkg::FLS_ST_FFW) begin
                            next_st = fls_pkg::FLS_ST_IDLE;
                        end else if (two_byte && !step) begin
                            next_step = 1'b1;
                        end else if (lock_op) begin
                            next_st = fls_pkg::FLS_ST_RDS;
                        end else begin
                            next_st = fls_pkg::FLS_ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= fls_pkg::FLS_ST_IDLE;
            phase <= 2'd0;
            step <= 1'b0;
            sr <= 8'h00;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            dq_oe_n <= 1'b1;
            dq_out <= 8'h00;
            flash_addr <= '0;
            last_byte <= 8'h00;
        end else begin
            st <= next_st;
            phase <= next_phase;
            step <= next_step;
            sr <= next_sr;
            ce_n <= next_ce_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            dq_oe_n <= next_dq_oe_n;
            dq_out <= next_dq_out;
            flash_addr <= next_flash_addr;
            last_byte <= next_last_byte;
        end
    end

    // held low during our reset so the device starts in read-array mode
    assign reset_powerdown_n = presetn && !pd;
    assign high_voltage_override_level = hv;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_we_with_ce: assert property (!we_n |-> !ce_n)
        else $error("write strobe without chip select");
    chk_we_oe_excl: assert property (!(!we_n && !oe_n))
        else $error("write and read strobes together");
    chk_drive_on_we: assert property (!we_n |-> !dq_oe_n && !oe_n == 0)
        else $error("write strobe without data drive");
    chk_confirm_order: assert property (
        $fell(we_n) && dq_out == `FLS_CMD_CLR_CONFIRM
        |-> step && op == fls_pkg::FLS_OP_CLR_LOCK)
        else $error("confirm byte outside its sequence");
    chk_pd_idles: assert property (pd |=> st == fls_pkg::FLS_ST_IDLE
        && ce_n && we_n && oe_n)
        else $error("engine active while powered down");
    chk_ff_last: assert property ($fell(busy) && lock_op && !pd
        |-> last_byte == `FLS_CMD_READ_ARRAY)
        else $error("lock operation did not end with read array");
    chk_err_clears: assert property (st == fls_pkg::FLS_ST_RDS
        && tick && phase == 2'd3 && sr[`FLS_SR_READY] && sr_bad
        |=> st == fls_pkg::FLS_ST_CLS)
        else $error("error not followed by clear status");
    chk_poll_busy: assert property (st == fls_pkg::FLS_ST_RDS
        && tick && phase == 2'd3 && !sr[`FLS_SR_READY] && !pd
        |=> st == fls_pkg::FLS_ST_RDS)
        else $error("left polling while device busy");
    chk_abort_flag: assert property (pd && busy |=> abort)
        else $error("abort not recorded");
    chk_idle_desel: assert property (st == fls_pkg::FLS_ST_IDLE
        && !$past(busy) |-> ce_n && dq_oe_n)
        else $error("idle controller selects the device");

endmodule : fls_host

// File: verif/fls_flash_model.sv
/*
 * Behavioural byte-wide flash device for the lock-bit host bench.
 * Assumes: pins are sampled on pclk; the bench sets the fault inputs
 * only while the host is idle.
 */
`timescale 1ns/1ps

module fls_flash_model #(
    parameter int ABORT_CYC = 8,
    parameter logic [7:0] ARRAY_BYTE = 8'h5A
) (
    input wire logic pclk,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic reset_powerdown_n,
    input wire logic high_voltage_override_level,
    input wire logic master_set,
    input wire logic vpp_low,
    input wire logic op_fail,
    input wire logic [7:0] busy_cycles,
    output logic [7:0] dq_in,
    output logic ready_busy_n
);
    // ----------------------------------------------------------------
    // command interface state
    // ----------------------------------------------------------------
    logic [31:0] cmd_log = 32'h0000_0000;
    logic [7:0] sr = 8'h00;
    logic setup = 1'b0;
    logic stat_mode = 1'b0;
    logic we_q = 1'b1;
    logic [7:0] last_dq = 8'h00;
    int busy_cnt = 0;
    int abort_cnt = 0;
    logic [7:0] rd_byte;

    task automatic take_cmd(input logic [7:0] b);
        logic [7:0] s;
        logic hv;
        s = sr;
        hv = high_voltage_override_level;
        cmd_log <= {cmd_log[23:0], b};
        stat_mode <= 1'b1;
        if (!setup) begin
            setup <= (b == 8'h60);
            if (b == 8'h50) sr <= 8'h00;
            if (b == 8'hFF) stat_mode <= 1'b0;
        end else begin
            setup <= 1'b0;
            if (b != 8'hD0 && b != 8'h01 && b != 8'hF1) begin
                sr <= sr | 8'h30;
            end else begin
                if (b == 8'hF1 ? !hv : master_set && !hv) begin
                    s[1] = 1'b1;
                end
                if (vpp_low) s = s | (b == 8'hD0 ? 8'h28 : 8'h18);
                if (op_fail) s = s | (b == 8'hD0 ? 8'h20 : 8'h10);
                sr <= s;
                busy_cnt <= (busy_cycles == 8'h00) ? 1 : int'(busy_cycles);
            end
        end
    endtask : take_cmd

    always @(posedge pclk) begin
        we_q <= we_n;
        if (!ce_n && !oe_n && reset_powerdown_n) begin
            last_dq <= rd_byte;
        end
        if (!reset_powerdown_n) begin
            setup <= 1'b0;
            stat_mode <= 1'b0;
            sr <= 8'h00;
            // busy held for ABORT_CYC cycles of reset, then aborted
            if (abort_cnt < ABORT_CYC) abort_cnt <= abort_cnt + 1;
            else busy_cnt <= 0;
        end else begin
            abort_cnt <= 0;
            if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
            // writes while busy are dropped
            if (we_n && !we_q && !ce_n && !dq_oe_n && busy_cnt == 0) begin
                take_cmd(dq_out);
            end
        end
    end

    assign ready_busy_n = (busy_cnt == 0);
    // no program or erase path: array contents never alter here
    assign rd_byte = stat_mode ? {busy_cnt == 0, 1'b0, sr[5:3], 1'b0, sr[1],
                                  1'b0} : ARRAY_BYTE;
    // released bus shows the inverse of the last byte, never a hold
    assign dq_in = (!ce_n && !oe_n && reset_powerdown_n) ? rd_byte
                                                         : ~last_dq;
endmodule : fls_flash_model

// File: verif/tb_flash_lock_bit_config_status.sv
/*
 * Self-checking bench for the lock-bit host controller.
 * Assumes: fls_host is zero-wait APB; fls_flash_model stands at the pins.
 */
`timescale 1ns/1ps

module tb_flash_lock_bit_config_status;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] dq_out, dq_in, busy_cycles;
    logic [19:0] flash_addr;
    logic dq_oe_n, ce_n, we_n, oe_n, err, ready_busy_n;
    logic reset_powerdown_n, high_voltage_override_level;
    logic master_set, vpp_low, op_fail;
    logic [15:0] lfsr;
    int mismatches, comparisons, i;

    fls_host u_fls_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .flash_addr, .dq_out, .dq_in,
        .dq_oe_n, .ce_n, .we_n, .oe_n, .reset_powerdown_n,
        .high_voltage_override_level, .ready_busy_n);
    fls_flash_model u_fls_flash_model (.pclk, .ce_n, .we_n, .oe_n, .dq_out,
        .dq_oe_n, .reset_powerdown_n, .high_voltage_override_level,
        .master_set, .vpp_low, .op_fail, .busy_cycles, .dq_in,
        .ready_busy_n);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [31:0] ctrl_word(input logic [2:0] op,
        input logic go, input logic hv, input logic pd, input logic clr);
        return {20'h0_0000, clr, pd, hv, go, 5'h00, op};
    endfunction : ctrl_word

    function automatic logic [7:0] exp_sr(input logic [2:0] op,
        input logic ms, input logic hv, input logic vpp, input logic fl);
        logic [7:0] s;
        logic e5;
        s = 8'h80;
        e5 = (op == 3'h1);
        if (op == 3'h3 ? !hv : ms && !hv) s[1] = 1'b1;
        if (vpp) s = s | (e5 ? 8'h28 : 8'h18);
        if (fl) s = s | (e5 ? 8'h20 : 8'h10);
        return s;
    endfunction : exp_sr

    task automatic wait_idle;
        int n;
        for (n = 0; n < 3000; n++) begin
            apb(1'b0, 12'h008, 32'h0000_0000);
            if (rd[8] === 1'b0) break;
        end
        check(n < 3000, 1'b1);
    endtask : wait_idle

    task automatic run_op(input logic [2:0] op, input logic ms,
        input logic hv, input logic vpp, input logic fl);
        logic [7:0] s, cf;
        logic e;
        logic [31:0] lx;
        s = exp_sr(op, ms, hv, vpp, fl);
        e = |(s & 8'h3A);
        cf = op == 3'h1 ? 8'hD0 : (op == 3'h2 ? 8'h01 : 8'hF1);
        lx = e ? {8'h60, cf, 8'h50, 8'hFF} : {8'h00, 8'h60, cf, 8'hFF};
        if (op == 3'h4) lx = 32'h0000_0050;
        if (op == 3'h5) lx = 32'h0000_00FF;
        lfsr = lfsr_next(lfsr);
        @(posedge pclk);
        master_set <= ms;
        vpp_low <= vpp;
        op_fail <= fl;
        busy_cycles <= lfsr[7:0];
        u_fls_flash_model.cmd_log = 32'h0000_0000;
        apb(1'b1, 12'h004, {12'h000, lfsr, 4'h3});
        apb(1'b1, 12'h000, ctrl_word(op, 1'b1, hv, 1'b0, 1'b0));
        wait_idle;
        check(high_voltage_override_level, hv);
        check(flash_addr, {lfsr, 4'h3});
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(u_fls_flash_model.cmd_log, lx);
        check(rd[12], 1'b1);
        if (op < 3'h4) begin
            check(rd[7:0], s);
            check(rd[10], e);
        end
        apb(1'b1, 12'h000, ctrl_word(3'h0, 1'b0, hv, 1'b0, 1'b1));
    endtask : run_op

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        master_set = 1'b0;
        vpp_low = 1'b0;
        op_fail = 1'b0;
        busy_cycles = 8'h04;
        mismatches = 0;
        comparisons = 0;
        lfsr = 16'h0045;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd, 32'h0000_0200);
        check(reset_powerdown_n, 1'b1);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        check(err, 1'b1);
        check(rd, 32'h0000_0000);
        // corner cases: each protection flavour once, op fail on clear and set master, vpp low on set block
        run_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        run_op(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
        run_op(3'h1, 1'b1, 1'b1, 1'b0, 1'b0);
        run_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b1);
        run_op(3'h3, 1'b0, 1'b0, 1'b0, 1'b0);
        run_op(3'h3, 1'b0, 1'b1, 1'b0, 1'b1);
        run_op(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
        run_op(3'h2, 1'b0, 1'b0, 1'b1, 1'b0);
        run_op(3'h4, 1'b0, 1'b0, 1'b0, 1'b0);
        run_op(3'h5, 1'b0, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < 16; i++) begin
            lfsr = lfsr_next(lfsr);
            run_op(3'h1 + {1'b0, lfsr[1:0] % 2'h3}, lfsr[2], lfsr[3],
                   lfsr[4] & lfsr[5], lfsr[6] & lfsr[7]);
        end
        // abort a long clear in mid-flight, then repeat it
        @(posedge pclk);
        busy_cycles <= 8'hF0;
        u_fls_flash_model.cmd_log = 32'h0000_0000;
        apb(1'b1, 12'h000, ctrl_word(3'h1, 1'b1, 1'b0, 1'b0, 1'b0));
        apb(1'b0, 12'h008, 32'h0000_0000);
        for (i = 0; i < 200 && rd[9] !== 1'b0; i++) begin
            apb(1'b0, 12'h008, 32'h0000_0000);
        end
        check(rd[9:8], 2'b01);
        apb(1'b1, 12'h000, ctrl_word(3'h4, 1'b1, 1'b0, 1'b0, 1'b0));
        apb(1'b1, 12'h000, ctrl_word(3'h0, 1'b0, 1'b0, 1'b1, 1'b0));
        check(ready_busy_n, 1'b0);
        repeat (20) @(posedge pclk);
        apb(1'b0, 12'h008, 32'h0000_0000);
        check(rd[11:8], 4'b1010);
        check(reset_powerdown_n, 1'b0);
        check(u_fls_flash_model.cmd_log, 32'h0000_60D0);
        apb(1'b1, 12'h000, ctrl_word(3'h0, 1'b0, 1'b0, 1'b0, 1'b1));
        run_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        report_and_stop;
    end

    initial begin
        #250000;
        mismatches++;
        $display("mismatch at %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule : tb_flash_lock_bit_config_status
